// ---- rtl/sra_pkg.sv ----
// constants, register map and framer states of the receive decode/align block
// assumes a 100 MHz system clock and an APB register port with 32-bit data
// Behaviour
// - decoded CMI violations pulse the coding error pin in serial use or in hardware mode with framing off
// - software mode logs CMI violations as a sticky event bit
// - lock indication shown on a pin, status bit and event bit
// - framing and alignment only in parallel mode with framing enabled
// - hunt for three F6 bytes then three 28 bytes, align bytes to it
// - hardware frame pulse marks third A2 byte for one byte clock
// - software chooses the frame pulse byte with a four-bit field
// - framing enable comes from a pin or a config bit, set before data
// - two good frames leave out-of-frame; alignment taken on entering in-frame
// - four bad frames declare out-of-frame, shown as status and event
// - out of frame, alignment and pulse position stay frozen
// - CMI with alignment off: frame pulse pin shows coding errors
// - loss alarm on a pin, a status bit and an event bit
// - fiber loss asserts after 3112 bit times without a transition
// - fiber loss clears after two framing words with no new loss
// - software picks one of four loss windows, 128 to 4096 bits
// - optional clear: at least 4 transitions in a sliding 32-bit window
// - transmit byte taken on falling edge, software may invert it
// - receive byte clock rises mid byte, software may invert it
// - on loss or unlock byte clock becomes reference, bytes forced zero
// - on loss or unlock serial clock becomes transmit clock, data zero
// - mode pin low is hardware mode, high is software mode
// - reference select low uses transmit clock, high the crystal
// - line select low is NRZ fiber, high is CMI coax
package sra_pkg;
    localparam logic [5:0] REG_CFG_IDX = 6'h00;
    localparam logic [5:0] REG_SUB_IDX = 6'h0a;
    localparam logic [5:0] REG_FRM_IDX = 6'h0c;
    localparam logic [5:0] REG_FPP_IDX = 6'h0d;
    localparam logic [5:0] REG_STA_IDX = 6'h0f;
    localparam logic [5:0] REG_EVT_IDX = 6'h10;
    localparam int CFG_CMI_BIT = 0;
    localparam int CFG_RXINV_BIT = 2;
    localparam int CFG_TXINV_BIT = 3;
    localparam int CFG_REF_BIT = 5;
    localparam int SUB_DIS_BIT = 7;
    localparam int FRM_LOSW_LSB = 0;
    localparam int FRM_LOSW_W = 2;
    localparam int FRM_EN_BIT = 3;
    localparam int FRM_DENS_BIT = 4;
    localparam int FPP_LSB = 3;
    localparam int FPP_W = 4;
    localparam int STA_LOCK_BIT = 0;
    localparam int STA_OOF_BIT = 1;
    localparam int STA_LOS_BIT = 2;
    localparam int EV_CMI = 0;
    localparam int EV_LOCK = 1;
    localparam int EV_OOF = 2;
    localparam int EV_LOS = 3;
    localparam int EV_W = 4;
    localparam logic [47:0] FRAME_WORD = 48'hf6f6f628_2828;
    localparam logic [3:0] HW_FP_BYTE = 4'h5;
    localparam int unsigned FRAME_BYTES_DFLT = 19440;
    localparam logic [1:0] FIND_FRAMES = 2'h2;
    localparam logic [2:0] LOSE_FRAMES = 3'h4;
    localparam logic [1:0] LOS_CLEAR_WORDS = 2'h2;
    localparam int NT_W = 13;
    localparam logic [12:0] LOS_HW_BITS = 13'hc28;
    localparam logic [12:0] LOS_WIN0 = 13'h080;
    localparam logic [12:0] LOS_WIN1 = 13'h200;
    localparam logic [12:0] LOS_WIN2 = 13'h400;
    localparam logic [12:0] LOS_WIN3 = 13'h1000;
    localparam int DENS_WIN = 32;
    localparam int DCNT_W = 6;
    localparam logic [5:0] DENS_MIN = 6'h04;
    // lock window is judged by the analog PLL, kept here for reference
    localparam int LOCK_PPM = 488;
    typedef enum logic [1:0] {
        FR_HUNT = 2'b00,
        FR_PRE = 2'b01,
        FR_INF = 2'b10
    } sra_frame_e;
endpackage : sra_pkg

// ---- rtl/sra_rx_core.sv ----
// receive decode, frame alignment, loss detection and output substitution
// assumes all pins except the APB port and nrst are asynchronous to clk and the line clock is far slower
`timescale 1ns/1ps
module sra_rx_core import sra_pkg::*; #(
    parameter int unsigned FRAME_BYTES = FRAME_BYTES_DFLT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_sw_select,
    input wire logic frame_detect_enable_pin,
    input wire logic reference_select_pin,
    input wire logic line_mode_pin,
    input wire logic parallel_mode_pin,
    input wire logic pll_lock_in,
    input wire logic coax_loss_in,
    input wire logic line_clock,
    input wire logic line_data,
    input wire logic line_data_late,
    input wire logic tx_parallel_clock,
    input wire logic [7:0] tx_parallel_byte,
    input wire logic crystal_input,
    input wire logic [1:0] tx_serial_clock_pair,
    output logic [7:0] rx_parallel_byte,
    output logic rx_parallel_clock,
    output logic rx_frame_pulse,
    output logic coding_error_out,
    output logic signal_loss_alarm,
    output logic lock_out,
    output logic [1:0] rx_serial_clock_pair,
    output logic [1:0] rx_serial_data_pair,
    output logic [7:0] tx_byte_captured
);
    localparam int unsigned FRAME_BITS = FRAME_BYTES * 8;
    localparam int FCW = $clog2(FRAME_BITS);
    localparam int BW = $clog2(FRAME_BYTES);
    localparam int SW = 21;

    logic [SW-1:0] sync1_q, sync2_q;
    logic hw_s, fde_s, ref_s, mode_s, par_s, lock_s, closs_s;
    logic lck_s, ld_s, ldl_s, txpc_s, xtal_s, txs_s;
    logic [7:0] txd_s;
    assign {hw_s, fde_s, ref_s, mode_s, par_s, lock_s, closs_s, lck_s, ld_s,
            ldl_s, txpc_s, xtal_s, txs_s, txd_s} = sync2_q;

    // register file and bus answer
    logic [7:0] cfg_q, cfg_d, sub_q, sub_d, frm_q, frm_d, fpp_q, fpp_d;
    logic [EV_W-1:0] ev_q, ev_d, ev_set, ev_clr;
    logic [31:0] rdata_d;
    logic pready_d, perr_d;
    // line side state
    logic lck_p_q, txpc_p_q, lock_p_q, oof_p_q, los_p_q;
    logic last_one_q, last_one_d, last_bit_q, last_bit_d, sbit_q, sbit_d;
    logic [47:0] sh_q, sh_d;
    logic [FCW-1:0] fcnt_q, fcnt_d;
    logic [BW-1:0] bidx_q, bidx_d;
    logic [2:0] bph_q, bph_d, bad_q, bad_d;
    logic [1:0] good_q, good_d, fw_q, fw_d;
    logic [7:0] acc_q, acc_d, obyte_q, obyte_d;
    logic [NT_W-1:0] nt_q, nt_d;
    logic [DENS_WIN-1:0] dh_q, dh_d;
    logic [DCNT_W-1:0] dcnt_q, dcnt_d;
    sra_frame_e st_q, st_d;
    logic los_q, los_d, fp_q, fp_d, cerr_q, cerr_d;
    logic [7:0] pbyte_d, txb_d;
    logic pclk_d, sclk_d, sdat_d;

    // mode decode
    logic sw, cmi_mode, frm_en, ref_clk, alarm, subst, bstb, tx_edge;
    logic bit_now, cerr, trans, match, fend, hit, wr, byte_done, align;
    logic [NT_W-1:0] win;
    logic [3:0] fp_pos;
    logic [5:0] idx;

    always_comb begin
        sw = hw_s;
        cmi_mode = sw ? cfg_q[CFG_CMI_BIT] : mode_s;
        frm_en = par_s & (sw ? frm_q[FRM_EN_BIT] : fde_s);
        ref_clk = (sw ? cfg_q[CFG_REF_BIT] : ref_s) ? xtal_s : txpc_s;
        alarm = los_q | ~lock_s;
        subst = alarm & ~(sw & sub_q[SUB_DIS_BIT]);
        fp_pos = sw ? fpp_q[FPP_LSB +: FPP_W] : HW_FP_BYTE;
        bstb = lck_s & ~lck_p_q;
        // falling edge by default, rising when software inverts
        tx_edge = (sw & cfg_q[CFG_TXINV_BIT]) ? (txpc_s & ~txpc_p_q)
                                              : (~txpc_s & txpc_p_q);
        case (frm_q[FRM_LOSW_LSB +: FRM_LOSW_W])
            2'h0: win = LOS_WIN0;
            2'h1: win = LOS_WIN1;
            2'h2: win = LOS_WIN2;
            default: win = LOS_WIN3;
        endcase
        if (!sw) begin
            win = LOS_HW_BITS;
        end
    end

    // cmi decode: first half 0 and second 1 is a zero, equal halves a one
    always_comb begin
        cerr = 1'b0;
        last_one_d = last_one_q;
        if (!cmi_mode) begin
            bit_now = ld_s;
        end else if (ld_s == ldl_s) begin
            bit_now = 1'b1;
            cerr = (ld_s == last_one_q);
            last_one_d = ld_s;
        end else begin
            bit_now = 1'b0;
            cerr = ld_s;
        end
        if (!bstb) begin
            last_one_d = last_one_q;
        end
    end

    // framer: shift every bit, so every offset is tried while hunting
    always_comb begin
        sh_d = sh_q;
        fcnt_d = fcnt_q;
        st_d = st_q;
        good_d = good_q;
        bad_d = bad_q;
        align = 1'b0;
        match = 1'b0;
        fend = fcnt_q == FCW'(FRAME_BITS - 1);
        if (bstb) begin
            sh_d = {sh_q[46:0], bit_now};
            match = sh_d == FRAME_WORD;
            fcnt_d = fend ? '0 : fcnt_q + 1'b1;
            case (st_q)
                FR_HUNT: begin
                    if (match) begin
                        fcnt_d = '0;
                        good_d = 2'h1;
                        st_d = FR_PRE;
                    end
                end
                FR_PRE: begin
                    if (fend && match) begin
                        good_d = good_q + 1'b1;
                        if (good_d == FIND_FRAMES) begin
                            st_d = FR_INF;
                            bad_d = '0;
                            align = 1'b1;
                        end
                    end else if (fend) begin
                        st_d = FR_HUNT;
                    end
                end
                FR_INF: begin
                    if (fend) begin
                        bad_d = match ? '0 : bad_q + 1'b1;
                        if (bad_d == LOSE_FRAMES) begin
                            st_d = FR_HUNT;
                        end
                    end
                end
                default: st_d = FR_HUNT;
            endcase
        end
        if (!frm_en) begin
            st_d = FR_HUNT;
        end
    end

    // byte assembly; the phase changes only when in-frame is entered
    always_comb begin
        acc_d = acc_q;
        bph_d = bph_q;
        obyte_d = obyte_q;
        bidx_d = bidx_q;
        fp_d = fp_q;
        byte_done = bstb && bph_q == 3'h7;
        if (bstb) begin
            acc_d = {acc_q[6:0], bit_now};
            bph_d = bph_q + 1'b1;
            if (!frm_en) begin
                fp_d = cmi_mode & cerr;
            end
        end
        if (byte_done || align) begin
            obyte_d = acc_d;
            bph_d = '0;
            bidx_d = (bidx_q == BW'(FRAME_BYTES - 1)) ? '0 : bidx_q + 1'b1;
            if (align) begin
                bidx_d = BW'(HW_FP_BYTE);
            end
            if (frm_en) begin
                // held for a whole byte, position frozen while out of frame
                fp_d = bidx_d == BW'(fp_pos);
            end
        end
    end

    // loss of signal on the fiber path, analog detector on coax
    always_comb begin
        trans = bit_now ^ last_bit_q;
        last_bit_d = bstb ? bit_now : last_bit_q;
        nt_d = nt_q;
        dh_d = dh_q;
        dcnt_d = dcnt_q;
        fw_d = fw_q;
        los_d = los_q;
        hit = 1'b0;
        if (cmi_mode) begin
            los_d = closs_s;
        end else if (bstb) begin
            nt_d = trans ? '0 : ((nt_q == win) ? nt_q : nt_q + 1'b1);
            dh_d = {dh_q[DENS_WIN-2:0], trans};
            dcnt_d = dcnt_q + DCNT_W'(trans) - DCNT_W'(dh_q[DENS_WIN-1]);
            hit = nt_d >= win;
            if (hit) begin
                los_d = 1'b1;
                fw_d = '0;
            end else if (los_q && sw && frm_q[FRM_DENS_BIT]) begin
                los_d = dcnt_d < DENS_MIN;
            end else if (los_q && match) begin
                fw_d = fw_q + 1'b1;
                los_d = fw_d != LOS_CLEAR_WORDS;
                if (!los_d) begin
                    fw_d = '0;
                end
            end
        end
    end

    // apb slave: answer one cycle after setup, errors on unmapped words
    always_comb begin
        idx = paddr[7:2];
        wr = psel & penable & pready & pwrite & ~pslverr;
        pready_d = psel & ~penable;
        perr_d = 1'b0;
        rdata_d = prdata;
        cfg_d = cfg_q;
        sub_d = sub_q;
        frm_d = frm_q;
        fpp_d = fpp_q;
        ev_clr = '0;
        if (pready_d) begin
            rdata_d = '0;
            case (idx)
                REG_CFG_IDX: rdata_d = 32'(cfg_q);
                REG_SUB_IDX: rdata_d = 32'(sub_q);
                REG_FRM_IDX: rdata_d = 32'(frm_q);
                REG_FPP_IDX: rdata_d = 32'(fpp_q);
                REG_STA_IDX: rdata_d = 32'({los_q, st_q != FR_INF, lock_s});
                REG_EVT_IDX: rdata_d = 32'(ev_q);
                default: perr_d = 1'b1;
            endcase
            if (paddr[1:0] != 2'h0) begin
                perr_d = 1'b1;
                rdata_d = '0;
            end
        end
        if (wr) begin
            case (idx)
                REG_CFG_IDX: cfg_d = pwdata[7:0];
                REG_SUB_IDX: sub_d = pwdata[7:0];
                REG_FRM_IDX: frm_d = pwdata[7:0];
                REG_FPP_IDX: fpp_d = pwdata[7:0];
                REG_EVT_IDX: ev_clr = pwdata[EV_W-1:0];
                default: ev_clr = '0;
            endcase
        end
    end

    // sticky events, a new event wins over a clear in the same cycle
    always_comb begin
        ev_set = '0;
        ev_set[EV_CMI] = sw & bstb & cmi_mode & cerr;
        ev_set[EV_LOCK] = lock_s ^ lock_p_q;
        ev_set[EV_OOF] = (st_q != FR_INF) & ~oof_p_q;
        ev_set[EV_LOS] = los_q & ~los_p_q;
        ev_d = (ev_q & ~ev_clr) | ev_set;
    end

    // pin outputs
    always_comb begin
        pbyte_d = subst ? '0 : obyte_q;
        pclk_d = subst ? ref_clk
                       : ((bph_q >= 3'h4) ^ (sw & cfg_q[CFG_RXINV_BIT]));
        sbit_d = bstb ? bit_now : sbit_q;
        sclk_d = subst ? txs_s : lck_s;
        sdat_d = subst ? 1'b0 : sbit_q;
        cerr_d = bstb & cmi_mode & cerr & ((~sw & ~frm_en) | ~par_s);
        txb_d = tx_edge ? txd_s : tx_byte_captured;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            {lck_p_q, txpc_p_q, lock_p_q, los_p_q} <= '0;
            oof_p_q <= 1'b1;
            {last_one_q, last_bit_q, sbit_q} <= '0;
            sh_q <= '0;
            fcnt_q <= '0;
            bidx_q <= '0;
            {bph_q, bad_q, good_q, fw_q} <= '0;
            {acc_q, obyte_q} <= '0;
            nt_q <= '0;
            dh_q <= '0;
            dcnt_q <= '0;
            st_q <= FR_HUNT;
            {los_q, fp_q, cerr_q} <= '0;
            {cfg_q, sub_q, frm_q, fpp_q} <= '0;
            ev_q <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rx_parallel_byte <= '0;
            rx_parallel_clock <= 1'b0;
            lock_out <= 1'b0;
            rx_serial_clock_pair <= 2'h1;
            rx_serial_data_pair <= 2'h1;
            tx_byte_captured <= '0;
        end else begin
            sync1_q <= {hw_sw_select, frame_detect_enable_pin,
                        reference_select_pin, line_mode_pin,
                        parallel_mode_pin, pll_lock_in, coax_loss_in,
                        line_clock, line_data, line_data_late,
                        tx_parallel_clock, crystal_input,
                        tx_serial_clock_pair[1], tx_parallel_byte};
            sync2_q <= sync1_q;
            lck_p_q <= lck_s;
            txpc_p_q <= txpc_s;
            lock_p_q <= lock_s;
            oof_p_q <= st_q != FR_INF;
            los_p_q <= los_q;
            last_one_q <= last_one_d;
            last_bit_q <= last_bit_d;
            sbit_q <= sbit_d;
            sh_q <= sh_d;
            fcnt_q <= fcnt_d;
            bidx_q <= bidx_d;
            bph_q <= bph_d;
            bad_q <= bad_d;
            good_q <= good_d;
            fw_q <= fw_d;
            acc_q <= acc_d;
            obyte_q <= obyte_d;
            nt_q <= nt_d;
            dh_q <= dh_d;
            dcnt_q <= dcnt_d;
            st_q <= st_d;
            los_q <= los_d;
            fp_q <= fp_d;
            cerr_q <= cerr_d;
            cfg_q <= cfg_d;
            sub_q <= sub_d;
            frm_q <= frm_d;
            fpp_q <= fpp_d;
            ev_q <= ev_d;
            prdata <= rdata_d;
            pready <= pready_d;
            pslverr <= perr_d;
            rx_parallel_byte <= pbyte_d;
            rx_parallel_clock <= pclk_d;
            lock_out <= lock_s;
            rx_serial_clock_pair <= {sclk_d, ~sclk_d};
            rx_serial_data_pair <= {sdat_d, ~sdat_d};
            tx_byte_captured <= txb_d;
        end
    end

    assign rx_frame_pulse = fp_q;
    assign coding_error_out = cerr_q;
    assign signal_loss_alarm = los_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_hunt_match;
        bstb && frm_en && st_q == FR_HUNT && match;
    endsequence

    chk_pattern_found: assert property (
        s_hunt_match |=> st_q == FR_PRE && fcnt_q == '0)
        else $error("pattern match did not start a frame");
    chk_fp_position: assert property (
        frm_en && rx_frame_pulse |-> bidx_q == BW'(fp_pos))
        else $error("frame pulse at wrong byte");
    chk_hw_fp_byte: assert property (
        !sw && frm_en && st_q == FR_INF && bstb && fend && match
        |=> rx_frame_pulse && obyte_q == FRAME_WORD[7:0])
        else $error("hardware frame pulse not on third A2");
    chk_align_entry: assert property (
        st_q == FR_INF && $past(st_q) != FR_INF |-> bph_q == '0)
        else $error("byte phase not aligned on entry");
    chk_oof_declare: assert property (
        frm_en && bstb && st_q == FR_INF && fend && !match
        && bad_q == LOSE_FRAMES - 1'b1 |=> st_q == FR_HUNT ##1 ev_q[EV_OOF])
        else $error("out of frame not declared");
    chk_frame_gate: assert property (
        !frm_en |=> st_q == FR_HUNT)
        else $error("framer active while disabled");
    chk_coding_err: assert property (
        coding_error_out |-> $past(bstb) && $past(cmi_mode))
        else $error("coding error without a line bit");
    chk_cmi_event: assert property (
        sw && bstb && cmi_mode && cerr |=> ev_q[EV_CMI])
        else $error("cmi violation not logged");
    chk_los_window: assert property (
        bstb && !cmi_mode && nt_d >= win |=> signal_loss_alarm)
        else $error("loss not raised after window");
    chk_subst_byte: assert property (
        subst |=> rx_parallel_byte == '0)
        else $error("parallel data not forced to zero");
    chk_subst_serial: assert property (
        subst |=> rx_serial_data_pair == 2'h1)
        else $error("serial data not forced to zero");
    chk_tx_capture: assert property (
        tx_edge |=> tx_byte_captured == $past(txd_s))
        else $error("transmit byte not captured");
endmodule : sra_rx_core

// ---- testbench/sra_line_src.sv ----
// line side source: recovered bit clock and NRZ bits, MSB first
// assumes the bench clock clk; the line clock halts between bursts
`timescale 1ns/1ps
module sra_line_src (
    input wire logic clk,
    output logic line_clock,
    output logic line_data
);
    initial begin
        line_clock = 1'b0;
        line_data = 1'b0;
    end
    // 160 ns bit: data set with the falling clock, taken on the rise
    task automatic send(input logic [7:0] q[$]);
        foreach (q[n]) begin
            for (int i = 7; i >= 0; i--) begin
                line_clock <= 1'b0;
                line_data <= q[n][i];
                repeat (8) @(posedge clk);
                line_clock <= 1'b1;
                repeat (8) @(posedge clk);
            end
        end
        line_clock <= 1'b0;
        @(posedge clk);
    endtask : send
endmodule : sra_line_src

// ---- testbench/tb_sra_rx_core.sv ----
// register and line tests of the receive decode/align block
// assumes the line source model and a short frame length
`timescale 1ns/1ps
module tb_sra_rx_core;
    import sra_pkg::*;
    localparam int FB = 8;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0] paddr, rx_parallel_byte, tx_byte_captured;
    logic [31:0] pwdata, prdata, rd;
    logic hw_sw_select, frame_detect_enable_pin, reference_select_pin;
    logic line_mode_pin, parallel_mode_pin, pll_lock_in, line_clock;
    logic line_data, rx_parallel_clock, rx_frame_pulse;
    logic tx_parallel_clock = 1'b0;
    logic fp_prev = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic coding_error_out, signal_loss_alarm, lock_out;
    logic [1:0] rx_serial_clock_pair, rx_serial_data_pair;
    int fails = 0;
    int n_compared = 0;
    int n_fp = 0;
    int n0;
    sra_line_src src (.clk, .line_clock, .line_data);
    sra_rx_core #(.FRAME_BYTES(FB)) dut (
        .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hw_sw_select, .frame_detect_enable_pin,
        .reference_select_pin, .line_mode_pin, .parallel_mode_pin,
        .pll_lock_in, .coax_loss_in(1'b0), .line_clock, .line_data,
        .line_data_late(1'b0), .tx_parallel_clock,
        .tx_parallel_byte(tx_byte), .crystal_input(1'b0),
        .tx_serial_clock_pair(2'b00), .rx_parallel_byte,
        .rx_parallel_clock, .rx_frame_pulse, .coding_error_out,
        .signal_loss_alarm, .lock_out, .rx_serial_clock_pair,
        .rx_serial_data_pair, .tx_byte_captured);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) tx_parallel_clock <= ~tx_parallel_clock;
    // counts rising edges of the frame pulse
    always @(posedge clk) begin
        fp_prev <= rx_frame_pulse;
        if (rx_frame_pulse && !fp_prev) n_fp <= n_fp + 1;
    end
    task automatic chk(input logic g, input logic e, input string m);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [5:0] i,
                       input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic frames(input int n, input logic [7:0] a1,
                          input logic [7:0] a2, input logic [7:0] fl);
        logic [7:0] q[$];
        for (int f = 0; f < n; f++)
            for (int b = 0; b < FB; b++)
                q.push_back(b < 3 ? a1 : (b < 6 ? a2 : fl));
        src.send(q);
        repeat (6) @(posedge clk);
    endtask : frames
    task automatic end_sim;
        $display("counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #400000;
        fails++;
        end_sim();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {frame_detect_enable_pin, reference_select_pin} = 2'b00;
        line_mode_pin = 1'b0;
        {hw_sw_select, parallel_mode_pin, pll_lock_in} = 3'b111;
        nrst = 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, 6'h3f, 8'h00);
        chk(perr, 1'b1, "unmapped read not refused");
        apb(1'b0, REG_STA_IDX, 8'h00);
        chk(rd[STA_LOCK_BIT], 1'b1, "lock status low");
        $display("test registers done");
        apb(1'b1, REG_FRM_IDX, 8'h08);
        frames(3, 8'hf6, 8'h28, 8'h55);
        apb(1'b0, REG_STA_IDX, 8'h00);
        chk(rd[STA_OOF_BIT], 1'b0, "not in frame");
        $display("test find frame done");
        frames(4, 8'h55, 8'h28, 8'h55);
        apb(1'b0, REG_STA_IDX, 8'h00);
        chk(rd[STA_OOF_BIT], 1'b1, "no out of frame");
        apb(1'b0, REG_EVT_IDX, 8'h00);
        chk(rd[EV_OOF], 1'b1, "no oof event");
        apb(1'b1, REG_EVT_IDX, (8'h01 << EV_OOF) | (8'h01 << EV_LOCK));
        apb(1'b0, REG_EVT_IDX, 8'h00);
        chk(rd[EV_OOF], 1'b0, "oof event not cleared");
        chk(rd[EV_LOCK], 1'b0, "lock event not cleared");
        $display("test lose frame done");
        frames(3, 8'hf6, 8'h28, 8'h55);
        frames(3, 8'h00, 8'h00, 8'h00);
        chk(signal_loss_alarm, 1'b1, "no loss alarm");
        chk(|rx_parallel_byte, 1'b0, "byte not forced");
        chk(rx_serial_data_pair[1], 1'b0, "serial not forced");
        apb(1'b0, REG_STA_IDX, 8'h00);
        chk(rd[STA_LOS_BIT], 1'b1, "no loss status");
        frames(3, 8'hf6, 8'h28, 8'h55);
        chk(signal_loss_alarm, 1'b0, "loss not cleared");
        $display("test loss done");
        pll_lock_in <= 1'b0;
        tx_byte <= 8'h3c;
        repeat (6) @(posedge clk);
        chk(lock_out, 1'b0, "lock pin high");
        chk(tx_byte_captured == 8'h3c, 1'b1, "tx byte not taken");
        chk(|rx_parallel_byte, 1'b0, "byte not forced");
        apb(1'b0, REG_EVT_IDX, 8'h00);
        chk(rd[EV_LOCK], 1'b1, "no lock event");
        $display("test unlock done");
        pll_lock_in <= 1'b1;
        {hw_sw_select, frame_detect_enable_pin} <= 2'b01;
        repeat (6) @(posedge clk);
        n0 = n_fp;
        frames(3, 8'hf6, 8'h28, 8'h55);
        chk(n_fp - n0 == 3, 1'b1, "hw frame pulse count");
        $display("test hardware pulse done");
        end_sim();
    end
endmodule : tb_sra_rx_core
